/* include/dac_ctl_pkg.sv */
package dac_ctl_pkg;

    // Register map on the host register port.
    localparam logic [11:0] GLOBAL_CTRL_OFS = 12'h0158;
    localparam logic [11:0] GLOBAL_STAT_OFS = 12'h015C;
    localparam logic [31:0] GLOBAL_CTRL_RST = 32'h0000_0000;

    // Number of converters served by the shared control register.
    localparam int CVT_NUM = 2;

    // Field positions, one bit per converter starting at the LSB given.
    localparam int PULSE_REQ_LSB = 0;
    localparam int RESET_REQ_LSB = 16;
    localparam int BUSY_LSB      = 0;
    localparam int FAULT_LSB     = 16;

    // Timing figures in their own units, and the clock they meet.
    localparam int CLK_MHZ       = 200;
    localparam int RST_LOW_NS    = 1000;
    localparam int RECOVER_NS    = 500;
    localparam int CONV_PULSE_NS = 100;

    // Least times round up to whole cycles.
    localparam int RST_LOW_CYC = (RST_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CYC    = (CONV_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W       = 8;

    // Conversion mode of one converter, as set by the converter channel logic.
    typedef enum logic [1:0] {
        MODE_SEQUENCER  = 2'h0,
        MODE_MAN_IMMED  = 2'h1,
        MODE_MAN_CTRL   = 2'h2
    } conv_mode_t;

    // Reset and post-reset configuration sequence of one converter.
    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,
        ST_RST_LOW  = 5'h02,
        ST_RECOVER  = 5'h04,
        ST_CFG_REQ  = 5'h08,
        ST_CFG_WAIT = 5'h10
    } seq_state_t;

endpackage

/* include/cvt_if.sv */
`timescale 1ns/1ps
// Signals between the shared control register and one converter sequencer.
interface cvt_if;
    logic rst_req;
    logic rst_ack;
    logic pulse_req;
    logic pulse_ack;
    logic cfg_done;
    logic xfer_busy;
    logic busy;
    logic rst_n;
    logic conv_pulse;
    logic cfg_req;

    modport seq (
        input  rst_req,
        input  pulse_req,
        input  cfg_done,
        input  xfer_busy,
        output rst_ack,
        output pulse_ack,
        output busy,
        output rst_n,
        output conv_pulse,
        output cfg_req
    );

    modport ctl (
        output rst_req,
        output pulse_req,
        output cfg_done,
        output xfer_busy,
        input  rst_ack,
        input  pulse_ack,
        input  busy,
        input  rst_n,
        input  conv_pulse,
        input  cfg_req
    );
endinterface

/* hdl/cvt_seq.sv */
`timescale 1ns/1ps
module cvt_seq
    import dac_ctl_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    cvt_if.seq        bus
);

    seq_state_t       state_r;
    logic [CNT_W-1:0] cnt_r;
    logic             pulse_r;
    logic [CNT_W-1:0] pulse_cnt_r;
    logic [CNT_W-1:0] low_len_r;
    logic [CNT_W-1:0] hi_len_r;

    ////////////////////////////////////////////////////////////////////////////
    // Reset pulse, recovery wait, then one configuration request and its wait.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else if (i_ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (bus.rst_req) begin
                        state_r <= ST_RST_LOW;
                        cnt_r   <= CNT_W'(RST_LOW_CYC - 1);
                    end
                end
                ST_RST_LOW: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_RECOVER;
                        cnt_r   <= CNT_W'(RECOVER_CYC - 1);
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_RECOVER: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_CFG_REQ;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_CFG_REQ: begin
                    state_r <= ST_CFG_WAIT;
                end
                ST_CFG_WAIT: begin
                    if (bus.cfg_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Pulses wait for an idle sequencer so that none starts in a reset cycle.
    assign bus.rst_ack   = (state_r == ST_IDLE) && bus.rst_req;
    assign bus.pulse_ack = bus.pulse_req && !pulse_r && (state_r == ST_IDLE) && !bus.rst_req;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion pulse of fixed width.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pulse_r     <= 1'b0;
            pulse_cnt_r <= '0;
        end else if (i_ce) begin
            if (bus.pulse_ack) begin
                pulse_r     <= 1'b1;
                pulse_cnt_r <= CNT_W'(CONV_CYC - 1);
            end else if (pulse_cnt_r != '0) begin
                pulse_cnt_r <= pulse_cnt_r - 1'b1;
            end else begin
                pulse_r <= 1'b0;
            end
        end
    end

    // Busy also covers serial transfers reported by the transfer engine.
    assign bus.busy       = (state_r != ST_IDLE) || bus.xfer_busy;
    assign bus.rst_n      = (state_r != ST_RST_LOW);
    assign bus.cfg_req    = (state_r == ST_CFG_REQ);
    assign bus.conv_pulse = pulse_r;

    ////////////////////////////////////////////////////////////////////////////
    // Helper counters of the lengths of the reset and pulse levels.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            low_len_r <= '0;
            hi_len_r  <= '0;
        end else if (i_ce) begin
            low_len_r <= bus.rst_n ? '0 : low_len_r + 1'b1;
            hi_len_r  <= pulse_r ? hi_len_r + 1'b1 : '0;
        end
    end

    property p_rst_width;
        @(posedge i_clk) disable iff (i_rst)
        $rose(bus.rst_n) |-> (low_len_r == CNT_W'(RST_LOW_CYC));
    endproperty
    a_rst_width: assert property (p_rst_width)
        else $error("Reset pin low for the wrong number of cycles.");

    property p_cfg_after_rst;
        @(posedge i_clk) disable iff (i_rst || !i_ce)
        $rose(bus.rst_n) |-> ##[100:300] bus.cfg_req;
    endproperty
    a_cfg_after_rst: assert property (p_cfg_after_rst)
        else $error("No configuration request after the reset phase.");

    property p_busy_in_reset;
        @(posedge i_clk) disable iff (i_rst)
        (!bus.rst_n || bus.cfg_req || (state_r == ST_CFG_WAIT)) |-> bus.busy;
    endproperty
    a_busy_in_reset: assert property (p_busy_in_reset)
        else $error("Busy clear during reset or configuration.");

    property p_pulse_width;
        @(posedge i_clk) disable iff (i_rst)
        $fell(pulse_r) |-> (hi_len_r == CNT_W'(CONV_CYC));
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("Conversion pulse has the wrong width.");

    property p_pulse_cause;
        @(posedge i_clk) disable iff (i_rst)
        $rose(pulse_r) |-> $past(bus.pulse_req) && $past(state_r == ST_IDLE);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("Conversion pulse without a request.");

endmodule

/* hdl/dac_global_control.sv */
`timescale 1ns/1ps
// What this block does
// - One shared control register holds a reset and a pulse request bit per converter.
// - Writing one to bit 16 or 17 drives that converter's active-low reset pin low for a reset.
// - When the recovery wait after the reset phase ends, a configuration request goes to that converter without software.
// - The reset request clears itself and busy stays set through reset and configuration.
// - In manual controlled mode a one in bit 0 or 1 gives one conversion pulse, then clears.
// - In sequencer or manual immediate mode a pulse request gives no pulse and reads back zero.
// - Status bit 0 or 1 shows busy while a transfer or reset is handled, recovery included.
module dac_global_control
    import dac_ctl_pkg::*;
(
    input  wire logic                 I_MCLK,
    input  wire logic                 I_SYS_RST,
    input  wire logic                 i_CE,
    input  wire logic [11:0]          i_REG_ADDR,
    input  wire logic                 i_REG_WR,
    input  wire logic [3:0]           i_REG_BE,
    input  wire logic [31:0]          i_REG_WDATA,
    input  wire logic                 i_REG_RD,
    output      logic [31:0]          o_REG_RDATA,
    output      logic                 o_REG_RVALID,
    input  wire logic [2*CVT_NUM-1:0] i_CVT_MODE,
    input  wire logic [CVT_NUM-1:0]   i_CVT_XFER_BUSY,
    input  wire logic [CVT_NUM-1:0]   i_CVT_CFG_DONE,
    input  wire logic [CVT_NUM-1:0]   i_CVT_FAULT_N,
    output      logic [CVT_NUM-1:0]   o_CVT_RST_N,
    output      logic [CVT_NUM-1:0]   o_CVT_CONV_PULSE,
    output      logic [CVT_NUM-1:0]   o_CVT_CFG_REQ
);

    localparam int RST_BYTE   = RESET_REQ_LSB / 8;
    localparam int PULSE_BYTE = PULSE_REQ_LSB / 8;

    logic [CVT_NUM-1:0] rst_req_r;
    logic [CVT_NUM-1:0] pulse_req_r;
    logic [CVT_NUM-1:0] rst_ack;
    logic [CVT_NUM-1:0] pulse_ack;
    logic [CVT_NUM-1:0] busy;
    logic [CVT_NUM-1:0] manual_ctl;
    logic [CVT_NUM-1:0] fault_r;
    logic               wr_ctrl;
    logic [31:0]        ctrl_view;
    logic [31:0]        stat_view;

    cvt_if u_cvt_if[CVT_NUM] ();

    // Only the documented register takes writes; other addresses are ignored.
    assign wr_ctrl = i_REG_WR && (i_REG_ADDR == GLOBAL_CTRL_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Per converter: mode decode, sequencer instance and its pin hookup.
    for (genvar i = 0; i < CVT_NUM; i++) begin : g_cvt
        assign manual_ctl[i] = (conv_mode_t'(i_CVT_MODE[2*i +: 2]) == MODE_MAN_CTRL);

        assign u_cvt_if[i].rst_req   = rst_req_r[i];
        // Gated by the live mode so a pending bit never fires after the mode has left.
        assign u_cvt_if[i].pulse_req = pulse_req_r[i] && manual_ctl[i];
        assign u_cvt_if[i].cfg_done  = i_CVT_CFG_DONE[i];
        assign u_cvt_if[i].xfer_busy = i_CVT_XFER_BUSY[i];
        assign rst_ack[i]            = u_cvt_if[i].rst_ack;
        assign pulse_ack[i]          = u_cvt_if[i].pulse_ack;
        assign busy[i]               = u_cvt_if[i].busy;
        assign o_CVT_RST_N[i]        = u_cvt_if[i].rst_n;
        assign o_CVT_CONV_PULSE[i]   = u_cvt_if[i].conv_pulse;
        assign o_CVT_CFG_REQ[i]      = u_cvt_if[i].cfg_req;

        cvt_seq u_seq (
            .i_clk (I_MCLK),
            .i_rst (I_SYS_RST),
            .i_ce  (i_CE),
            .bus   (u_cvt_if[i])
        );

        property p_reset_cause;
            @(posedge I_MCLK) disable iff (I_SYS_RST)
            $fell(o_CVT_RST_N[i]) |-> $past(rst_req_r[i]);
        endproperty
        a_reset_cause: assert property (p_reset_cause)
            else $error("Reset pin fell without a reset request.");

        property p_rst_req_clears;
            @(posedge I_MCLK) disable iff (I_SYS_RST || !i_CE)
            (rst_ack[i] && !(wr_ctrl && i_REG_BE[RST_BYTE] && i_REG_WDATA[RESET_REQ_LSB + i]))
                |=> !rst_req_r[i] && !o_CVT_RST_N[i];
        endproperty
        a_rst_req_clears: assert property (p_rst_req_clears)
            else $error("Reset request did not clear when the reset began.");

        property p_no_pulse_req;
            @(posedge I_MCLK) disable iff (I_SYS_RST || !i_CE)
            !manual_ctl[i] |=> !pulse_req_r[i];
        endproperty
        a_no_pulse_req: assert property (p_no_pulse_req)
            else $error("Pulse request held outside manual controlled mode.");

        property p_pulse_needs_mode;
            @(posedge I_MCLK) disable iff (I_SYS_RST)
            $rose(o_CVT_CONV_PULSE[i]) |-> $past(manual_ctl[i]);
        endproperty
        a_pulse_needs_mode: assert property (p_pulse_needs_mode)
            else $error("Conversion pulse outside manual controlled mode.");

        property p_status_busy;
            @(posedge I_MCLK) disable iff (I_SYS_RST)
            (i_REG_RD && i_CE && (i_REG_ADDR == GLOBAL_STAT_OFS) && !o_CVT_RST_N[i])
                |=> o_REG_RDATA[BUSY_LSB + i];
        endproperty
        a_status_busy: assert property (p_status_busy)
            else $error("Status read shows idle during a reset.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request bits: a one sets, zero does nothing, the acknowledge clears.
    // A set in the same cycle as the acknowledge wins, so no request is lost.
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            rst_req_r   <= GLOBAL_CTRL_RST[RESET_REQ_LSB +: CVT_NUM];
            pulse_req_r <= GLOBAL_CTRL_RST[PULSE_REQ_LSB +: CVT_NUM];
        end else if (i_CE) begin
            for (int i = 0; i < CVT_NUM; i++) begin
                rst_req_r[i] <= (wr_ctrl && i_REG_BE[RST_BYTE]
                                 && i_REG_WDATA[RESET_REQ_LSB + i])
                                || (rst_req_r[i] && !rst_ack[i]);
                // Outside manual controlled mode the bit is dropped at once.
                pulse_req_r[i] <= manual_ctl[i]
                                  && ((wr_ctrl && i_REG_BE[PULSE_BYTE]
                                       && i_REG_WDATA[PULSE_REQ_LSB + i])
                                      || (pulse_req_r[i] && !pulse_ack[i]));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault pins are registered so the read data never sees a moving level.
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            fault_r <= '0;
        end else if (i_CE) begin
            fault_r <= ~i_CVT_FAULT_N;
        end
    end

    // Register views; unused and reserved bits read as zero.
    always_comb begin
        ctrl_view = '0;
        stat_view = '0;
        ctrl_view[RESET_REQ_LSB +: CVT_NUM] = rst_req_r;
        ctrl_view[PULSE_REQ_LSB +: CVT_NUM] = pulse_req_r;
        stat_view[BUSY_LSB +: CVT_NUM]      = busy;
        stat_view[FAULT_LSB +: CVT_NUM]     = fault_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero for an unmapped address.
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            o_REG_RDATA  <= 32'h0000_0000;
            o_REG_RVALID <= 1'b0;
        end else if (i_CE) begin
            o_REG_RVALID <= i_REG_RD;
            if (i_REG_RD) begin
                case (i_REG_ADDR)
                    GLOBAL_CTRL_OFS: o_REG_RDATA <= ctrl_view;
                    GLOBAL_STAT_OFS: o_REG_RDATA <= stat_view;
                    default:         o_REG_RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    property p_reset_clears;
        @(posedge I_MCLK)
        I_SYS_RST |=> (rst_req_r == '0) && (pulse_req_r == '0) && !o_REG_RVALID;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("Request bits not zero after system reset.");

    property p_upper_write_inert;
        @(posedge I_MCLK) disable iff (I_SYS_RST || !i_CE)
        (wr_ctrl && (i_REG_WDATA[17:16] == 2'h0) && (i_REG_WDATA[1:0] == 2'h0))
            |=> ($countones(rst_req_r) <= $countones($past(rst_req_r)));
    endproperty
    a_upper_write_inert: assert property (p_upper_write_inert)
        else $error("A zero write raised a reset request.");

endmodule

/* tb/cvt_model.sv */
`timescale 1ns/1ps
// Behavioural stand-in for the two converters and the serial engine that configures them.
module cvt_model
    import dac_ctl_pkg::*;
#(
    parameter int FAST_CYC = 2,
    parameter int SLOW_CYC = 40
)(
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic [CVT_NUM-1:0] i_rst_n,
    input  wire logic [CVT_NUM-1:0] i_cfg_req,
    input  wire logic [CVT_NUM-1:0] i_slow,
    input  wire logic [CVT_NUM-1:0] i_fault,
    output      logic [CVT_NUM-1:0] o_cfg_done,
    output      logic [CVT_NUM-1:0] o_fault_n
);
    int cnt_r [CVT_NUM];

    ////////////////////////////////////////////////////////////////////////////////////////
    // Configuration takes a while; a converter held in reset never finishes one.
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < CVT_NUM; i++) begin
            o_cfg_done[i] <= 1'b0;
            if (i_rst || !i_rst_n[i]) begin
                cnt_r[i] <= 0;
            end else if (i_cfg_req[i]) begin
                cnt_r[i] <= i_slow[i] ? SLOW_CYC : FAST_CYC;
            end else if (cnt_r[i] > 0) begin
                cnt_r[i]      <= cnt_r[i] - 1;
                o_cfg_done[i] <= (cnt_r[i] == 1);
            end
        end
    end

    // The fault pin only falls while the bench asks for a fault.
    assign o_fault_n = ~i_fault;
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb
    import dac_ctl_pkg::*;
;
    logic                 mclk;
    logic                 sys_rst;
    logic                 ce;
    logic [11:0]          addr;
    logic [31:0]          wdata;
    logic [31:0]          rdata;
    logic [3:0]           be;
    logic                 wr;
    logic                 rd;
    logic                 rvalid;
    logic [2*CVT_NUM-1:0] mode;
    logic [CVT_NUM-1:0]   xfer;
    logic [CVT_NUM-1:0]   cfg_done;
    logic [CVT_NUM-1:0]   fault_n;
    logic [CVT_NUM-1:0]   rst_n;
    logic [CVT_NUM-1:0]   pulse;
    logic [CVT_NUM-1:0]   cfg_req;
    logic [CVT_NUM-1:0]   slow;
    logic [CVT_NUM-1:0]   fault;
    logic [CVT_NUM-1:0]   prev_p;
    logic [31:0]          d;
    int                   lo_cnt [CVT_NUM];
    int                   gap_cnt [CVT_NUM];
    int                   pw_cnt [CVT_NUM];
    int                   np_cnt [CVT_NUM];
    int                   cfg_cnt [CVT_NUM];
    int                   n_errors;
    int                   compares;

    dac_global_control dut (
        .I_MCLK           (mclk),
        .I_SYS_RST        (sys_rst),
        .i_CE             (ce),
        .i_REG_ADDR       (addr),
        .i_REG_WR         (wr),
        .i_REG_BE         (be),
        .i_REG_WDATA      (wdata),
        .i_REG_RD         (rd),
        .o_REG_RDATA      (rdata),
        .o_REG_RVALID     (rvalid),
        .i_CVT_MODE       (mode),
        .i_CVT_XFER_BUSY  (xfer),
        .i_CVT_CFG_DONE   (cfg_done),
        .i_CVT_FAULT_N    (fault_n),
        .o_CVT_RST_N      (rst_n),
        .o_CVT_CONV_PULSE (pulse),
        .o_CVT_CFG_REQ    (cfg_req)
    );

    cvt_model model (
        .i_clk      (mclk),
        .i_rst      (sys_rst),
        .i_rst_n    (rst_n),
        .i_cfg_req  (cfg_req),
        .i_slow     (slow),
        .i_fault    (fault),
        .o_cfg_done (cfg_done),
        .o_fault_n  (fault_n)
    );

    // Free-running 200 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin monitor: reset low time, recovery gap, config requests and conversion pulses.
    always @(negedge mclk) begin
        for (int i = 0; i < CVT_NUM; i++) begin
            if (cfg_req[i] === 1'b1) cfg_cnt[i]++;
            else if (rst_n[i] !== 1'b1) lo_cnt[i]++;
            else if (lo_cnt[i] > 0 && cfg_cnt[i] == 0) gap_cnt[i]++;
            if (pulse[i] === 1'b1) pw_cnt[i]++;
            if (pulse[i] === 1'b1 && prev_p[i] !== 1'b1) np_cnt[i]++;
        end
        prev_p = pulse;
    end

    // Cleared just after a rising edge so it never races the monitor.
    task automatic clr_mon();
        @(posedge mclk);
        #1;
        for (int i = 0; i < CVT_NUM; i++) begin
            lo_cnt[i] = 0;
            gap_cnt[i] = 0;
            pw_cnt[i] = 0;
            np_cnt[i] = 0;
            cfg_cnt[i] = 0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Verdict; also the landing place of every wait that runs out.
    task automatic end_sim();
        $display("TB: compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_up(input string nm);
        n_errors++;
        $display("BAD %s expected completion seen timeout", nm);
        end_sim();
    endtask

    // One-cycle write strobe, driven on the falling edge.
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] b);
        @(negedge mclk);
        addr = a;
        wdata = v;
        be = b;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask

    // Read answer arrives one cycle after the strobe is taken.
    task automatic reg_rd(input logic [11:0] a, output logic [31:0] v);
        @(negedge mclk);
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        v = rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Full reset cycle of one converter; a slow partner keeps busy up through configuration.
    task automatic reset_cvt(input int i, input logic sl);
        int k;
        logic [31:0] v;
        slow[i] = sl;
        clr_mon();
        reg_wr(GLOBAL_CTRL_OFS, 32'h0001_0000 << i, 4'h4);
        repeat (4) @(negedge mclk);
        reg_rd(GLOBAL_CTRL_OFS, v);
        chk("rst_req_self_clear", v, 32'h0000_0000);
        reg_rd(GLOBAL_STAT_OFS, v);
        chk("busy_in_reset", v, 32'h1 << (BUSY_LSB + i));
        for (k = 0; k < 1000 && cfg_cnt[i] == 0; k++) @(negedge mclk);
        if (cfg_cnt[i] == 0) give_up("cfg_req");
        reg_rd(GLOBAL_STAT_OFS, v);
        if (sl) chk("busy_in_config", v, 32'h1 << (BUSY_LSB + i));
        for (k = 0; k < 100 && v !== 32'h0; k++) reg_rd(GLOBAL_STAT_OFS, v);
        if (v !== 32'h0) give_up("busy_after_config");
        chk("rst_low_cycles", lo_cnt[i], RST_LOW_CYC);
        chk("recover_cycles", gap_cnt[i], RECOVER_CYC);
        chk("cfg_req_cycles", cfg_cnt[i], 1);
        chk("other_untouched", lo_cnt[1-i], 0);
    endtask

    // Pulse request under a mode pair; only manual controlled converters may fire.
    task automatic pulse_try(input logic [3:0] m, input logic [1:0] mask);
        logic [31:0] v;
        int e;
        @(negedge mclk);
        mode = m;
        reg_rd(GLOBAL_STAT_OFS, v);
        chk("idle_before_pulse", v, 32'h0);
        clr_mon();
        reg_wr(GLOBAL_CTRL_OFS, {30'h0, mask}, 4'h1);
        repeat (3) @(negedge mclk);
        reg_rd(GLOBAL_CTRL_OFS, v);
        chk("pulse_req_readback", v, 32'h0);
        repeat (30) @(negedge mclk);
        for (int i = 0; i < CVT_NUM; i++) begin
            e = (mask[i] && m[2*i +: 2] == MODE_MAN_CTRL) ? 1 : 0;
            chk("pulse_count", np_cnt[i], e);
            chk("pulse_width", pw_cnt[i], e * CONV_CYC);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        addr = 12'h000;
        wdata = 32'h0000_0000;
        be = 4'h0;
        wr = 1'b0;
        rd = 1'b0;
        mode = 4'hA;
        xfer = 2'h0;
        slow = 2'h0;
        fault = 2'h0;
        n_errors = 0;
        compares = 0;
        repeat (10) @(negedge mclk);
        sys_rst = 1'b0;
        reg_rd(GLOBAL_CTRL_OFS, d);
        chk("ctrl_reset", d, GLOBAL_CTRL_RST);
        reg_rd(GLOBAL_STAT_OFS, d);
        chk("stat_reset", d, 32'h0);
        reg_rd(12'h150, d);
        chk("unmapped_read", d, 32'h0);
        reset_cvt(0, 1'b1);
        reset_cvt(1, 1'b0);
        // Every mode appears on each converter, with both requests in one write.
        for (int m = 0; m < 4; m++) pulse_try({2'(m), 2'(3 - m)}, 2'b11);
        pulse_try(4'hA, 2'b01);
        // A write made while the clock enable is low must be lost entirely.
        ce = 1'b0;
        reg_wr(GLOBAL_CTRL_OFS, 32'h0003_0003, 4'hF);
        ce = 1'b1;
        // Zero writes, reserved bits and other addresses must change nothing.
        clr_mon();
        reg_wr(GLOBAL_CTRL_OFS, 32'hFFFC_FFFC, 4'hF);
        reg_wr(GLOBAL_STAT_OFS, 32'h0003_0003, 4'hF);
        reg_wr(12'h150, 32'h0003_0003, 4'hF);
        repeat (30) @(negedge mclk);
        chk("no_reset", lo_cnt[0] + lo_cnt[1], 0);
        chk("no_pulse", np_cnt[0] + np_cnt[1], 0);
        reg_rd(GLOBAL_CTRL_OFS, d);
        chk("ctrl_zero", d, 32'h0);
        // Busy follows serial transfers as well; the fault pin shows through.
        xfer = 2'b10;
        fault = 2'b01;
        repeat (3) @(negedge mclk);
        reg_rd(GLOBAL_STAT_OFS, d);
        chk("busy_fault", d, (32'h1 << (BUSY_LSB + 1)) | (32'h1 << FAULT_LSB));
        xfer = 2'b00;
        fault = 2'b00;
        end_sim();
    end
endmodule
